/* inc/trc_map.svh */
// Command codes, lengths, register offsets and reset values
`ifndef TRC_MAP_SVH
`define TRC_MAP_SVH
`define TRC_SUB_REVERT   8'h45
`define TRC_SUB_PPS      8'h4A
`define TRC_SUB_MASK     8'h4D
`define TRC_SUB_OPT      8'h4E
`define TRC_LEN_QUERY    5'h01
`define TRC_LEN_QUERY2   5'h02
`define TRC_LEN_REVERT   5'h02
`define TRC_LEN_PPS_SET  5'h10
`define TRC_LEN_MASK_SET 5'h05
`define TRC_LEN_OPT_SET  5'h02
`define TRC_BUF_BYTES    5'h10
`define TRC_SEG_IO       8'h03
`define TRC_SEG_TIMING   8'h05
`define TRC_SEG_UTC      8'h0B
`define TRC_SEG_LOW      8'h02
`define TRC_SEG_HIGH     8'h08
`define TRC_SEG_MOST     8'hFD
`define TRC_SEG_ALL      8'hFF
`define TRC_MASK_RST     32'hFFFFFFC0
`define TRC_SW_RST       8'h01
`define TRC_TB_RST       1'b1
`define TRC_POL_RST      1'b0
`define TRC_OFS_RST      64'h0000000000000000
`define TRC_THR_RST      32'h43960000
`define TRC_THR_CLAMP    32'h4D8F0D18
`define TRC_SW_OFF       8'h00
`define TRC_SW_ON        8'h01
`define TRC_SW_ALWAYS    8'h02
`define TRC_SW_ONE       8'h03
`define TRC_SW_THREE     8'h04
`define TRC_SATS_ONE     4'h1
`define TRC_SATS_THREE   4'h3
`define TRC_BIT_FIX      5'h08
`define TRC_BIT_IO_LO    5'h1E
`define TRC_BIT_IO_HI    5'h1F
`define TRC_REG_STATUS   5'h00
`define TRC_REG_MASK     5'h04
`define TRC_REG_OFS_HI   5'h08
`define TRC_REG_OFS_LO   5'h0C
`define TRC_REG_THR      5'h10
`define TRC_REG_ENV      5'h14
`define TRC_REG_BIAS     5'h18
`endif

/* inc/trc_pkg.sv */
// Types shared by the command block
`default_nettype none
package trc_pkg;
  typedef enum logic [1:0] {ST_RX, ST_EXEC, ST_LOAD, ST_SEND} trc_state_type;
  typedef struct packed {
    logic [7:0]  driver_sw;
    logic        time_base;
    logic        polarity;
    logic [63:0] offset;
    logic [31:0] threshold;
  } trc_pps_cfg_type;
  typedef struct packed {
    logic       fix_active;
    logic       overdet;
    logic [3:0] sats;
  } trc_env_type;
endpackage
`default_nettype wire

/* hdl/trc_cmd_config.sv */
// Configuration command interpreter with pulse gating and output mask
`include "trc_map.svh"
`default_nettype none
module trc_cmd_config (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Avalon-MM register slave
  input  wire logic [4:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  output var  logic [31:0]              avs_readdata,
  output var  logic                     avs_waitrequest,
  // Command byte stream, subcode first
  input  wire logic                     rx_valid,
  input  wire logic [7:0]               rx_data,
  input  wire logic                     rx_last,
  output var  logic                     rx_ready,
  // Report byte stream
  output var  logic                     tx_valid,
  output var  logic [7:0]               tx_data,
  output var  logic                     tx_last,
  input  wire logic                     tx_ready,
  // Pulse path
  input  wire logic                     pps_tick,
  output var  logic                     pps_out,
  output var  trc_pkg::trc_pps_cfg_type pps_cfg,
  // Automatic output gating
  input  wire logic                     auto_req,
  input  wire logic [4:0]               auto_bit,
  input  wire logic                     auto_port_b,
  input  wire logic                     fix_complete,
  input  wire logic                     out_timer_done,
  input  wire logic                     io_opt_en,
  output var  logic                     auto_grant,
  // Storage side
  output var  logic                     nv_store,
  output var  logic                     revert_stb,
  output var  logic [7:0]               revert_seg
);

  trc_pkg::trc_state_type   state_q;
  trc_pkg::trc_pps_cfg_type cfg_q;
  trc_pkg::trc_env_type     env_q;
  logic [7:0]   rx_buf_q [16];
  logic [4:0]   cnt_q;
  logic [4:0]   len_q;
  logic         ovf_q;
  logic         rx_ready_q;
  logic [31:0]  mask_q;
  logic [31:0]  bias_q;
  logic [7:0]   sub_q;
  logic [127:0] rep_q;
  logic [4:0]   rep_len_q;
  logic [4:0]   idx_q;
  logic         tx_valid_q;
  logic [7:0]   tx_data_q;
  logic         tx_last_q;
  logic         pps_out_q;
  logic         auto_grant_q;
  logic         nv_store_q;
  logic         revert_stb_q;
  logic [7:0]   revert_seg_q;
  logic [31:0]  rdata_q;
  logic         wait_q;
  logic         seg_ok;
  logic         revert_go;
  logic         pps_query;
  logic         pps_set;
  logic         mask_query;
  logic         mask_set;
  logic         opt_query;
  logic         opt_set;
  logic         opt_valid;
  logic         reply_go;
  logic         rst_timing;
  logic         rst_io;
  logic [31:0]  thr_new;
  logic         sats_ok;
  logic         bias_ok;
  logic         pps_en;
  logic         mask_ok;
  logic         extra_ok;
  logic [7:0]   seg;
  logic         rx_take;
  logic         bus_go;

  assign rx_take = rx_valid && rx_ready_q;
  assign seg     = rx_buf_q[1];
  assign bus_go  = (avs_read || avs_write) && wait_q;

  // Decode of the collected command; bad lengths are dropped silently
  always_comb begin
    seg_ok = ((seg >= `TRC_SEG_LOW) && (seg <= `TRC_SEG_HIGH)) ||
             (seg == `TRC_SEG_UTC) || (seg == `TRC_SEG_MOST) ||
             (seg == `TRC_SEG_ALL);
    revert_go  = (rx_buf_q[0] == `TRC_SUB_REVERT) &&
                 (len_q == `TRC_LEN_REVERT) && seg_ok;
    pps_query  = (rx_buf_q[0] == `TRC_SUB_PPS) &&
                 ((len_q == `TRC_LEN_QUERY) ||
                  (len_q == `TRC_LEN_QUERY2));
    pps_set    = (rx_buf_q[0] == `TRC_SUB_PPS) &&
                 (len_q == `TRC_LEN_PPS_SET);
    mask_query = (rx_buf_q[0] == `TRC_SUB_MASK) &&
                 (len_q == `TRC_LEN_QUERY);
    mask_set   = (rx_buf_q[0] == `TRC_SUB_MASK) &&
                 (len_q == `TRC_LEN_MASK_SET);
    opt_query  = (rx_buf_q[0] == `TRC_SUB_OPT) &&
                 (len_q == `TRC_LEN_QUERY);
    opt_set    = (rx_buf_q[0] == `TRC_SUB_OPT) &&
                 (len_q == `TRC_LEN_OPT_SET);
    opt_valid  = opt_set && (seg >= `TRC_SW_ALWAYS) &&
                 (seg <= `TRC_SW_THREE);
    reply_go   = !ovf_q && (revert_go || pps_query || pps_set ||
                 mask_query || mask_set || opt_query || opt_set);
    rst_timing = revert_go && ((seg == `TRC_SEG_TIMING) ||
                 (seg == `TRC_SEG_MOST) || (seg == `TRC_SEG_ALL));
    rst_io     = revert_go && ((seg == `TRC_SEG_IO) ||
                 (seg == `TRC_SEG_MOST) || (seg == `TRC_SEG_ALL));
    thr_new    = {rx_buf_q[12], rx_buf_q[13], rx_buf_q[14], rx_buf_q[15]};
    if (thr_new > `TRC_THR_CLAMP) begin
      thr_new = `TRC_THR_CLAMP;
    end
  end

  // Pulse gating from switch mode, satellite count and bias estimate
  always_comb begin
    case (cfg_q.driver_sw)
      `TRC_SW_ON, `TRC_SW_ALWAYS: sats_ok = 1'b1;
      `TRC_SW_ONE: begin
        sats_ok = env_q.overdet ? (env_q.sats >= `TRC_SATS_ONE) :
                  env_q.fix_active;
      end
      `TRC_SW_THREE: begin
        sats_ok = env_q.overdet ? (env_q.sats >= `TRC_SATS_THREE) :
                  env_q.fix_active;
      end
      default: sats_ok = 1'b0;
    endcase
    // Positive floats order like unsigned words, so no float compare
    bias_ok = bias_q[31] || (bias_q <= cfg_q.threshold);
    pps_en  = sats_ok && bias_ok;
  end

  // Automatic output gating; port A packets bypass the mask
  always_comb begin
    mask_ok  = !auto_port_b || mask_q[auto_bit];
    extra_ok = 1'b1;
    if (auto_bit == `TRC_BIT_FIX) begin
      extra_ok = fix_complete && out_timer_done;
    end
    if ((auto_bit == `TRC_BIT_IO_LO) || (auto_bit == `TRC_BIT_IO_HI)) begin
      extra_ok = io_opt_en;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= trc_pkg::ST_RX;
    end else begin
      case (state_q)
        trc_pkg::ST_RX: begin
          if (rx_take && rx_last) begin
            state_q <= trc_pkg::ST_EXEC;
          end
        end
        trc_pkg::ST_EXEC: begin
          state_q <= reply_go ? trc_pkg::ST_LOAD : trc_pkg::ST_RX;
        end
        trc_pkg::ST_LOAD: state_q <= trc_pkg::ST_SEND;
        trc_pkg::ST_SEND: begin
          if (tx_ready && tx_last_q) begin
            state_q <= trc_pkg::ST_RX;
          end
        end
        default: state_q <= trc_pkg::ST_RX;
      endcase
    end
  end

  // Byte collection; bytes past the buffer mark the packet as dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q      <= 5'h00;
      len_q      <= 5'h00;
      ovf_q      <= 1'b0;
      rx_ready_q <= 1'b0;
    end else begin
      rx_ready_q <= (state_q == trc_pkg::ST_RX) && !(rx_take && rx_last);
      if (rx_take) begin
        if (cnt_q == `TRC_BUF_BYTES) begin
          ovf_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
        if (rx_last) begin
          len_q <= (cnt_q == `TRC_BUF_BYTES) ? cnt_q : cnt_q + 5'h01;
          cnt_q <= 5'h00;
        end
      end else if (state_q == trc_pkg::ST_LOAD) begin
        ovf_q <= 1'b0;
      end else if (state_q == trc_pkg::ST_EXEC) begin
        ovf_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rx_take && (cnt_q < `TRC_BUF_BYTES)) begin
      rx_buf_q[cnt_q[3:0]] <= rx_data;
    end
  end

  // Pulse settings; a revert of the timing segment restores defaults
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q.driver_sw <= `TRC_SW_RST;
      cfg_q.time_base <= `TRC_TB_RST;
      cfg_q.polarity  <= `TRC_POL_RST;
      cfg_q.offset    <= `TRC_OFS_RST;
      cfg_q.threshold <= `TRC_THR_RST;
      nv_store_q      <= 1'b0;
    end else begin
      nv_store_q <= 1'b0;
      if (state_q == trc_pkg::ST_EXEC && !ovf_q) begin
        if (rst_timing) begin
          cfg_q.driver_sw <= `TRC_SW_RST;
          cfg_q.time_base <= `TRC_TB_RST;
          cfg_q.polarity  <= `TRC_POL_RST;
          cfg_q.offset    <= `TRC_OFS_RST;
          cfg_q.threshold <= `TRC_THR_RST;
        end else if (pps_set) begin
          cfg_q.driver_sw <= rx_buf_q[1];
          cfg_q.time_base <= rx_buf_q[2][0];
          cfg_q.polarity  <= rx_buf_q[3][0];
          // Signed offset passes on unchanged; negative means earlier
          cfg_q.offset    <= {rx_buf_q[4], rx_buf_q[5], rx_buf_q[6],
                              rx_buf_q[7], rx_buf_q[8], rx_buf_q[9],
                              rx_buf_q[10], rx_buf_q[11]};
          cfg_q.threshold <= thr_new;
          nv_store_q      <= 1'b1;
        end else if (opt_valid) begin
          cfg_q.driver_sw <= seg;
          nv_store_q      <= 1'b1;
        end
      end
    end
  end

  // Output mask, first received byte lands in the top bits
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= `TRC_MASK_RST;
    end else if (state_q == trc_pkg::ST_EXEC && !ovf_q) begin
      if (rst_io) begin
        mask_q <= `TRC_MASK_RST;
      end else if (mask_set) begin
        mask_q <= {rx_buf_q[1], rx_buf_q[2], rx_buf_q[3],
                   rx_buf_q[4]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      revert_stb_q <= 1'b0;
      revert_seg_q <= 8'h00;
    end else begin
      revert_stb_q <= (state_q == trc_pkg::ST_EXEC) && !ovf_q &&
                      revert_go;
      if ((state_q == trc_pkg::ST_EXEC) && revert_go) begin
        revert_seg_q <= seg;
      end
    end
  end

  // Report build and send; the mask never touches this path
  always_ff @(posedge clk) begin
    if (rst) begin
      sub_q      <= 8'h00;
      rep_q      <= 128'h0;
      rep_len_q  <= 5'h00;
      idx_q      <= 5'h00;
      tx_valid_q <= 1'b0;
      tx_data_q  <= 8'h00;
      tx_last_q  <= 1'b0;
    end else begin
      case (state_q)
        trc_pkg::ST_EXEC: sub_q <= rx_buf_q[0];
        trc_pkg::ST_LOAD: begin
          // Built after the update so a set returns the new values
          case (sub_q)
            `TRC_SUB_PPS: begin
              rep_q     <= {cfg_q.driver_sw, 7'h00, cfg_q.time_base,
                            7'h00, cfg_q.polarity, cfg_q.offset,
                            cfg_q.threshold, 8'h00};
              rep_len_q <= `TRC_LEN_PPS_SET;
            end
            `TRC_SUB_MASK: begin
              rep_q     <= {mask_q, 96'h0};
              rep_len_q <= `TRC_LEN_MASK_SET;
            end
            `TRC_SUB_OPT: begin
              rep_q     <= {cfg_q.driver_sw, 120'h0};
              rep_len_q <= `TRC_LEN_OPT_SET;
            end
            default: begin
              rep_q     <= {revert_seg_q, 120'h0};
              rep_len_q <= `TRC_LEN_REVERT;
            end
          endcase
          tx_valid_q <= 1'b1;
          tx_data_q  <= sub_q;
          tx_last_q  <= 1'b0;
          idx_q      <= 5'h01;
        end
        trc_pkg::ST_SEND: begin
          if (tx_ready) begin
            if (tx_last_q) begin
              tx_valid_q <= 1'b0;
              tx_last_q  <= 1'b0;
            end else begin
              tx_data_q <= rep_q[127:120];
              rep_q     <= {rep_q[119:0], 8'h00};
              tx_last_q <= (idx_q == rep_len_q - 5'h01);
              idx_q     <= idx_q + 5'h01;
            end
          end
        end
        default: tx_valid_q <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pps_out_q    <= 1'b0;
      auto_grant_q <= 1'b0;
    end else begin
      pps_out_q    <= (pps_tick && pps_en) ^ cfg_q.polarity;
      auto_grant_q <= auto_req && mask_ok && extra_ok;
    end
  end

  // Register slave: one wait cycle, write lands as waitrequest rises again
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end else if (!wait_q) begin
      wait_q <= 1'b1;
    end else if (bus_go) begin
      wait_q <= 1'b0;
      case (avs_address)
        `TRC_REG_STATUS: rdata_q <= {16'h0000, cfg_q.driver_sw, 5'h00,
                                     pps_en, cfg_q.time_base,
                                     cfg_q.polarity};
        `TRC_REG_MASK:   rdata_q <= mask_q;
        `TRC_REG_OFS_HI: rdata_q <= cfg_q.offset[63:32];
        `TRC_REG_OFS_LO: rdata_q <= cfg_q.offset[31:0];
        `TRC_REG_THR:    rdata_q <= cfg_q.threshold;
        `TRC_REG_ENV:    rdata_q <= {26'h0000000, env_q};
        `TRC_REG_BIAS:   rdata_q <= bias_q;
        default:         rdata_q <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      env_q  <= 6'h00;
      bias_q <= 32'h00000000;
    end else if (avs_write && !wait_q) begin
      if (avs_address == `TRC_REG_ENV) begin
        env_q <= avs_writedata[5:0];
      end
      if (avs_address == `TRC_REG_BIAS) begin
        bias_q <= avs_writedata;
      end
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign rx_ready        = rx_ready_q;
  assign tx_valid        = tx_valid_q;
  assign tx_data         = tx_data_q;
  assign tx_last         = tx_last_q;
  assign pps_out         = pps_out_q;
  assign pps_cfg         = cfg_q;
  assign auto_grant      = auto_grant_q;
  assign nv_store        = nv_store_q;
  assign revert_stb      = revert_stb_q;
  assign revert_seg      = revert_seg_q;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence exec_s;
    (state_q == trc_pkg::ST_EXEC) && reply_go;
  endsequence
  sequence first_byte_s;
    tx_valid_q && (tx_data_q == sub_q);
  endsequence

  reply_start_a: assert property (exec_s |-> ##2 first_byte_s)
    else $error("report did not start with its subcode");
  thr_clamp_a: assert property (cfg_q.threshold <= `TRC_THR_CLAMP)
    else $error("threshold above clamp");
  bias_off_a: assert property (
    (pps_tick && !bias_q[31] && (bias_q > cfg_q.threshold)) |=>
    (pps_out_q == $past(cfg_q.polarity)))
    else $error("pulse driven with bias over threshold");
  pulse_level_a: assert property (
    (pps_tick && pps_en && !cfg_q.polarity) |=> pps_out_q)
    else $error("positive pulse missing");
  sw_always_a: assert property (
    (pps_tick && bias_ok && (cfg_q.driver_sw == `TRC_SW_ALWAYS)) |=>
    (pps_out_q != $past(cfg_q.polarity)))
    else $error("always mode did not pulse");
  port_a_pass_a: assert property (
    (auto_req && !auto_port_b && (auto_bit < `TRC_BIT_FIX)) |=>
    auto_grant_q)
    else $error("port A packet was masked");
  mask_block_a: assert property (
    (auto_req && auto_port_b && !mask_q[auto_bit]) |=>
    !auto_grant_q)
    else $error("masked packet granted");
  fix_timer_a: assert property (
    (auto_req && (auto_bit == `TRC_BIT_FIX) &&
     !(fix_complete && out_timer_done)) |=> !auto_grant_q)
    else $error("fix packet granted early");
  io_option_a: assert property (
    (auto_req && (auto_bit >= `TRC_BIT_IO_LO) && !io_opt_en) |=>
    !auto_grant_q)
    else $error("raw or kinetic packet granted without option");
  nv_on_change_a: assert property (
    $changed(cfg_q) |-> (nv_store_q || $past(rst_timing)))
    else $error("setting change not stored");
  mask_reset_a: assert property (
    $fell(rst) |-> (mask_q == `TRC_MASK_RST))
    else $error("mask default wrong");

endmodule
`default_nettype wire

/* verif/trc_host_model.sv */
// Host model that sends command packets and gathers the reports
`default_nettype none
module trc_host_model (
  // Clock
  input  wire logic       clk,
  // Command stream to the block
  output var  logic       rx_valid,
  output var  logic [7:0] rx_data,
  output var  logic       rx_last,
  input  wire logic       rx_ready,
  // Report stream from the block
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output var  logic       tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic slow = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'hA5;
    rx_last  = 1'b0;
  end
  // A stalling sink proves each report byte is held
  always @(posedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
  // Packet right aligned in p; no reply within 60 cycles gives rn 0
  task automatic xfer(input logic [4:0] n, input logic [127:0] p,
                      output logic [4:0] rn, output logic [127:0] r);
    logic [127:0] s;
    int           t;
    s = p << (8 * (16 - n));
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_data  <= s[127 - 8 * i -: 8];
      rx_last  <= (i == n - 1);
      do @(posedge clk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    rx_data  <= ~rx_data;
    r = '0;
    rn = '0;
    t = 0;
    while (t < 60) begin
      @(posedge clk);
      t++;
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        r = {r[119:0], tx_data};
        rn++;
        if (tx_last === 1'b1) t = 60;
      end
    end
  endtask
endmodule
`default_nettype wire

/* verif/timing_receiver_cmd_config_test.sv */
// Self-checking bench for the configuration command block
`default_nettype none
module timing_receiver_cmd_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [4:0]   cl;
    logic [127:0] c;
    logic [4:0]   rl;
    logic [127:0] r;
  } trc_row_type;
  trc_row_type rows[$];
  logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0] avs_address = 5'h00, auto_bit = 5'h00, rn;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic pps_tick = 1'b0, auto_req = 1'b0, auto_port_b = 1'b1;
  logic fix_complete = 1'b0, out_timer_done = 1'b0, io_opt_en = 1'b0;
  logic avs_waitrequest, rx_valid, rx_last, rx_ready, tx_valid, tx_last;
  logic tx_ready, pps_out, auto_grant, nv_store, revert_stb;
  logic [7:0] rx_data, tx_data, revert_seg;
  logic [127:0] r;
  trc_pkg::trc_pps_cfg_type pps_cfg;
  int fail_count = 0, tests_run = 0, nv_n = 0, rv_n = 0;
  trc_cmd_config dut_u (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .rx_valid, .rx_data,
    .rx_last, .rx_ready, .tx_valid, .tx_data, .tx_last, .tx_ready, .pps_tick,
    .pps_out, .pps_cfg, .auto_req, .auto_bit, .auto_port_b, .fix_complete,
    .out_timer_done, .io_opt_en, .auto_grant, .nv_store, .revert_stb,
    .revert_seg);
  trc_host_model host_u (.clk, .rx_valid, .rx_data, .rx_last, .rx_ready,
                         .tx_valid, .tx_data, .tx_last, .tx_ready);
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    nv_n += (nv_store === 1'b1);
    rv_n += (revert_stb === 1'b1);
  end
  task automatic chk(input logic [135:0] s, e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t got %0h want %0h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  // a selects the gating path, otherwise a second tick is sent
  task automatic pulse(input logic a, input logic [4:0] b, input logic e);
    auto_req <= a;
    pps_tick <= !a;
    auto_bit <= b;
    @(posedge clk);
    auto_req <= 1'b0;
    pps_tick <= 1'b0;
    @(negedge clk);
    chk(a ? auto_grant : pps_out, e);
    @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop;
  end
  initial begin
    rows.push_back('{5'h01, 128'h4D, 5'h05, 128'h4DFFFFFFC0});
    rows.push_back('{5'h02, 128'h4A00, 5'h10,
      128'h4A010100000000000000000043960000});
    rows.push_back('{5'h05, 128'h4D00000000, 5'h05, 128'h4D00000000});
    rows.push_back('{5'h01, 128'h4D, 5'h05, 128'h4D00000000});
    rows.push_back('{5'h05, 128'h4D12345678, 5'h05, 128'h4D12345678});
    rows.push_back('{5'h03, 128'h4D0102, 5'h00, 128'h0});
    rows.push_back('{5'h02, 128'h4E04, 5'h02, 128'h4E04});
    rows.push_back('{5'h01, 128'h4E, 5'h02, 128'h4E04});
    rows.push_back('{5'h10, 128'h4A020001BFF00000000000007F800000, 5'h10,
      128'h4A020001BFF00000000000004D8F0D18});
    rows.push_back('{5'h02, 128'h4509, 5'h00, 128'h0});
    rows.push_back('{5'h01, 128'h4D, 5'h05, 128'h4D12345678});
    rows.push_back('{5'h02, 128'h4503, 5'h02, 128'h4503});
    rows.push_back('{5'h01, 128'h4D, 5'h05, 128'h4DFFFFFFC0});
    rows.push_back('{5'h02, 128'h45FF, 5'h02, 128'h45FF});
    rows.push_back('{5'h01, 128'h4A, 5'h10,
      128'h4A010100000000000000000043960000});
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    host_u.slow = 1'b1;
    foreach (rows[i]) begin
      host_u.xfer(rows[i].cl, rows[i].c, rn, r);
      chk({rn, r}, {rows[i].rl, rows[i].r});
    end
    host_u.slow = 1'b0;
    chk(nv_n, 2);
    chk({rv_n, revert_seg}, {32'h2, 8'hFF});
    // Mid-run reset: outputs at rest, rx_ready one edge after release
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({avs_waitrequest, rx_ready, tx_valid, pps_out}, 4'h8);
    chk({avs_readdata, auto_grant, nv_store, revert_stb}, 35'h0);
    chk(revert_seg, 8'h00);
    chk(pps_cfg, {8'h01, 1'b1, 1'b0, 64'h0, 32'h43960000});
    @(posedge clk);
    @(negedge clk);
    chk({avs_waitrequest, rx_ready, tx_valid, pps_out}, 4'hC);
    @(posedge clk);
    bus(1'b1, 5'h04, 32'h0);
    bus(1'b0, 5'h04, 32'h0);
    chk(q, 32'hFFFFFFC0);
    bus(1'b0, 5'h1C, 32'h0);
    chk(q, 32'h0);
    pulse(1'b0, 5'h00, 1'b1);
    bus(1'b1, 5'h18, 32'h43970000);
    pulse(1'b0, 5'h00, 1'b0);
    bus(1'b1, 5'h18, 32'h43950000);
    host_u.xfer(5'h02, 128'h4E04, rn, r);
    chk({rn, r}, {5'h02, 128'h4E04});
    bus(1'b1, 5'h14, 32'h12);
    bus(1'b0, 5'h14, 32'h0);
    chk(q, 32'h00000012);
    pulse(1'b0, 5'h00, 1'b0);
    bus(1'b1, 5'h14, 32'h13);
    pulse(1'b0, 5'h00, 1'b1);
    bus(1'b1, 5'h14, 32'h20);
    pulse(1'b0, 5'h00, 1'b1);
    bus(1'b1, 5'h14, 32'h00);
    pulse(1'b0, 5'h00, 1'b0);
    host_u.xfer(5'h10, 128'h4A020101000000000000000043960000, rn, r);
    chk({rn, r}, {5'h10, 128'h4A020101000000000000000043960000});
    chk(pps_cfg, {8'h02, 1'b1, 1'b1, 64'h0, 32'h43960000});
    bus(1'b0, 5'h00, 32'h0);
    chk(q, 32'h00000207);
    bus(1'b0, 5'h18, 32'h0);
    chk(q, 32'h43950000);
    pulse(1'b0, 5'h00, 1'b0);
    pulse(1'b1, 5'h00, 1'b0);
    pulse(1'b1, 5'h06, 1'b1);
    pulse(1'b1, 5'h08, 1'b0);
    fix_complete <= 1'b1;
    pulse(1'b1, 5'h08, 1'b0);
    out_timer_done <= 1'b1;
    pulse(1'b1, 5'h08, 1'b1);
    pulse(1'b1, 5'h1E, 1'b0);
    io_opt_en <= 1'b1;
    pulse(1'b1, 5'h1F, 1'b1);
    auto_port_b <= 1'b0;
    pulse(1'b1, 5'h00, 1'b1);
    report_and_stop;
  end
endmodule
`default_nettype wire
